/* File: src/mtmr_top.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Eight-bit up-counter, free-running or wrapping at a modulo limit.
// - Sources: bus clock, fixed-frequency clock, pin rising, pin falling.
// - Pin is the source only when the upper select bit is set.
// - Prescaler divides by 1, 2, 4 up to 256.
// - Overflow interrupt request can be enabled or disabled.
// - Counting continues during wait mode.
// - All stop modes halt counting; no wake-up from stop.
// - Deep stop wake-up or light stop reset restores reset state.
// - Light stop exit by interrupt keeps state and resumes.
// - Debug mode suspends counting; resumes from held value.
// - External pin is synchronised to the bus clock.
// - Status/control: flag 7, enable 6, clear 5, halt 4, zeros below.
// - Clock config: upper two zero, source select, four-bit prescale.
// - Count and modulo limit each readable as eight-bit registers.
// - Read-only flag sets when count rolls from limit to zero.
// - Flag clears by read while set, then write zero.
// - Writing clear bit one or any modulo write clears the flag.
// - Clear bit resets count to zero; halt bit stops counting.
// - Halt bit freezes the count while set.
// - Select codes: 00 bus, 01 fixed, 10 pin fall, 11 pin rise.
// - Reset sets halt; clearing it resumes from the held count.
// - Limit zero free-runs; otherwise wrap after matching the limit.
// - An overflow between read and zero write abandons the clear.
module mtmr_top
	import mtmr_pkg::*;
#(
	parameter int COUNT_WIDTH = 8,
	parameter int PRESCALE_WIDTH = 8
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic ext_count_pin,
	input wire logic fixed_freq_clock,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic deep_stop_wake,
	input wire logic light_stop_reset,
	input wire logic debug_active,
	output logic overflow_irq
);

	typedef struct packed {
		logic [COUNT_WIDTH-1:0] count;
		logic [COUNT_WIDTH-1:0] wrap_limit;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic counter_halt;
		logic [1:0] clock_source_select;
		logic [3:0] prescale_select;
		mtmr_clr_e clr_state;
		logic fixed_last;
		logic pre_clear;
		logic irq;
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} mtmr_top_s;

	mtmr_top_s state_reg;
	mtmr_top_s state_next;

	logic pin_rise;
	logic pin_fall;
	logic src_tick;
	logic count_tick;
	logic setup;
	logic wr_en;
	logic rd_en;
	logic state_reset;
	logic overflow;
	logic run;

	function automatic logic [7:0] status_byte(input mtmr_top_s s);
		logic [7:0] b;
		b = 8'h00;
		b[MTMR_OVERFLOW_FLAG_BIT] = s.overflow_flag;
		b[MTMR_IRQ_ENABLE_BIT] = s.overflow_irq_enable;
		b[MTMR_COUNTER_HALT_BIT] = s.counter_halt;
		return b;
	endfunction

	function automatic logic is_addr(input logic [7:0] a,
		input logic [7:0] ref_addr);
		return a == ref_addr;
	endfunction

	mtmr_pin_sync u_pin_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.ext_count_pin(ext_count_pin),
		.pin_rise(pin_rise),
		.pin_fall(pin_fall)
	);

	// Counting is suspended in stop and debug, and while halted.
	assign run = ~state_reg.counter_halt & ~stop_mode & ~debug_active;

	always_comb
	begin
		case (state_reg.clock_source_select)
			MTMR_SRC_BUS: src_tick = 1'b1;
			MTMR_SRC_FIXED: src_tick = fixed_freq_clock & ~state_reg.fixed_last;
			MTMR_SRC_PIN_FALL: src_tick = pin_fall;
			MTMR_SRC_PIN_RISE: src_tick = pin_rise;
			default: src_tick = 1'b1;
		endcase
	end

	mtmr_prescaler #(
		.WIDTH(PRESCALE_WIDTH)
	) u_prescaler (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(state_reg.pre_clear),
		.tick_in(src_tick & run),
		.prescale_select(state_reg.prescale_select),
		.tick_out(count_tick)
	);

	assign setup = psel & ~penable;
	// Writes land at the access edge, where the master samples pready high.
	assign wr_en = psel & penable & state_reg.ready & pwrite & pstrb[0];
	assign rd_en = setup & ~pwrite;
	assign state_reset = deep_stop_wake | light_stop_reset;

	// Wrap when the limit is matched, or at all-ones when free-running.
	assign overflow = count_tick &&
		((state_reg.wrap_limit != '0) ?
		(state_reg.count == state_reg.wrap_limit) :
		(state_reg.count == {COUNT_WIDTH{1'b1}}));

	always_comb
	begin
		state_next = state_reg;
		state_next.fixed_last = fixed_freq_clock;
		state_next.pre_clear = 1'b0;
		state_next.ready = setup;
		state_next.slverr = 1'b0;

		if (count_tick)
		begin
			if (overflow)
				state_next.count = '0;
			else
				state_next.count = state_reg.count + 1'b1;
		end

		// Reads are answered in the access cycle from state at setup.
		if (rd_en)
		begin
			state_next.rdata = 32'h0000_0000;
			if (is_addr(paddr, MTMR_STATUS_CONTROL_ADDR))
			begin
				state_next.rdata[7:0] = status_byte(state_reg);
				if (state_reg.overflow_flag)
					state_next.clr_state = MTMR_CLR_ARMED;
			end
			else if (is_addr(paddr, MTMR_CLOCK_CONFIG_ADDR))
				state_next.rdata[5:0] = {state_reg.clock_source_select,
					state_reg.prescale_select};
			else if (is_addr(paddr, MTMR_COUNT_VALUE_ADDR))
				state_next.rdata[COUNT_WIDTH-1:0] = state_reg.count;
			else if (is_addr(paddr, MTMR_WRAP_LIMIT_ADDR))
				state_next.rdata[COUNT_WIDTH-1:0] = state_reg.wrap_limit;
			else if (!is_addr(paddr, MTMR_POWER_CTRL_ADDR))
				state_next.slverr = 1'b1;
			else
				state_next.rdata[3:0] = {deep_stop_wake, stop_mode,
					wait_mode, debug_active};
		end

		if (setup & pwrite)
		begin
			if (!(is_addr(paddr, MTMR_STATUS_CONTROL_ADDR) ||
				is_addr(paddr, MTMR_CLOCK_CONFIG_ADDR) ||
				is_addr(paddr, MTMR_COUNT_VALUE_ADDR) ||
				is_addr(paddr, MTMR_WRAP_LIMIT_ADDR) ||
				is_addr(paddr, MTMR_POWER_CTRL_ADDR)))
				state_next.slverr = 1'b1;
		end

		if (wr_en)
		begin
			if (is_addr(paddr, MTMR_STATUS_CONTROL_ADDR))
			begin
				state_next.overflow_irq_enable =
					pwdata[MTMR_IRQ_ENABLE_BIT];
				state_next.counter_halt =
					pwdata[MTMR_COUNTER_HALT_BIT];
				if (!pwdata[MTMR_OVERFLOW_FLAG_BIT] &&
					state_reg.clr_state == MTMR_CLR_ARMED)
					state_next.overflow_flag = 1'b0;
				state_next.clr_state = MTMR_CLR_IDLE;
				if (pwdata[MTMR_COUNTER_CLEAR_BIT])
				begin
					state_next.count = '0;
					state_next.pre_clear = 1'b1;
					state_next.overflow_flag = 1'b0;
				end
			end
			else if (is_addr(paddr, MTMR_CLOCK_CONFIG_ADDR))
			begin
				state_next.clock_source_select =
					pwdata[MTMR_CLKSRC_LSB +: 2];
				state_next.prescale_select =
					pwdata[MTMR_PRESCALE_LSB +: 4];
			end
			else if (is_addr(paddr, MTMR_WRAP_LIMIT_ADDR))
			begin
				state_next.wrap_limit = pwdata[COUNT_WIDTH-1:0];
				state_next.count = '0;
				state_next.pre_clear = 1'b1;
				state_next.overflow_flag = 1'b0;
				state_next.clr_state = MTMR_CLR_IDLE;
			end
		end

		// A fresh overflow wins over any clear and disarms a pending one.
		if (overflow)
		begin
			state_next.overflow_flag = 1'b1;
			state_next.clr_state = MTMR_CLR_IDLE;
		end

		state_next.irq = state_next.overflow_flag &
			state_next.overflow_irq_enable;

		case (state_reg.clr_state)
			MTMR_CLR_IDLE: ;
			MTMR_CLR_ARMED: ;
			default: state_next.clr_state = MTMR_CLR_IDLE;
		endcase

		if (state_reset)
		begin
			state_next.count = MTMR_COUNT_RESET;
			state_next.wrap_limit = MTMR_WRAP_RESET;
			state_next.overflow_flag = 1'b0;
			state_next.overflow_irq_enable = 1'b0;
			state_next.counter_halt = MTMR_HALT_RESET;
			state_next.clock_source_select = MTMR_CLKSRC_RESET;
			state_next.prescale_select = MTMR_PRESCALE_RESET;
			state_next.clr_state = MTMR_CLR_IDLE;
			state_next.pre_clear = 1'b1;
			state_next.irq = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_reg <= '0;
			state_reg.counter_halt <= MTMR_HALT_RESET;
			state_reg.clr_state <= MTMR_CLR_IDLE;
		end
		else
			state_reg <= state_next;
	end

	assign pready = state_reg.ready;
	assign prdata = state_reg.rdata;
	assign pslverr = state_reg.slverr;
	assign overflow_irq = state_reg.irq;

endmodule
`default_nettype wire

/* File: src/mtmr_pkg.sv */
package mtmr_pkg;

	// Register byte addresses on the APB bus, one aligned word each.
	localparam logic [7:0] MTMR_STATUS_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] MTMR_CLOCK_CONFIG_ADDR = 8'h04;
	localparam logic [7:0] MTMR_COUNT_VALUE_ADDR = 8'h08;
	localparam logic [7:0] MTMR_WRAP_LIMIT_ADDR = 8'h0C;
	localparam logic [7:0] MTMR_POWER_CTRL_ADDR = 8'h10;

	// Field positions.
	localparam int MTMR_OVERFLOW_FLAG_BIT = 7;
	localparam int MTMR_IRQ_ENABLE_BIT = 6;
	localparam int MTMR_COUNTER_CLEAR_BIT = 5;
	localparam int MTMR_COUNTER_HALT_BIT = 4;
	localparam int MTMR_CLKSRC_LSB = 4;
	localparam int MTMR_PRESCALE_LSB = 0;
	localparam int MTMR_DEBUG_BIT = 0;
	localparam int MTMR_WAIT_BIT = 1;
	localparam int MTMR_STOP_BIT = 2;
	localparam int MTMR_DEEP_STOP_BIT = 3;

	// Values after reset.
	localparam logic [7:0] MTMR_COUNT_RESET = 8'h00;
	localparam logic [7:0] MTMR_WRAP_RESET = 8'h00;
	localparam logic [1:0] MTMR_CLKSRC_RESET = 2'h0;
	localparam logic [3:0] MTMR_PRESCALE_RESET = 4'h0;
	localparam logic MTMR_HALT_RESET = 1'b1;

	// Clock source codes.
	localparam logic [1:0] MTMR_SRC_BUS = 2'h0;
	localparam logic [1:0] MTMR_SRC_FIXED = 2'h1;
	localparam logic [1:0] MTMR_SRC_PIN_FALL = 2'h2;
	localparam logic [1:0] MTMR_SRC_PIN_RISE = 2'h3;

	localparam logic [3:0] MTMR_PRESCALE_MAX = 4'h8;

	typedef enum logic [1:0] {
		MTMR_CLR_IDLE,
		MTMR_CLR_ARMED
	} mtmr_clr_e;

endpackage

/* File: src/mtmr_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser with edge detection on the settled copy.
module mtmr_pin_sync
	import mtmr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ext_count_pin,
	output logic pin_rise,
	output logic pin_fall
);

	typedef struct packed {
		logic meta;
		logic stable;
		logic last;
	} mtmr_sync_s;

	mtmr_sync_s state_reg;
	mtmr_sync_s state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.meta = ext_count_pin;
		state_next.stable = state_reg.meta;
		state_next.last = state_reg.stable;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign pin_rise = state_reg.stable & ~state_reg.last;
	assign pin_fall = ~state_reg.stable & state_reg.last;

endmodule
`default_nettype wire

/* File: src/mtmr_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
// Divides a stream of source ticks by two to the power of the select code, codes above 8 taken as 8.
module mtmr_prescaler
	import mtmr_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [3:0] prescale_select,
	output logic tick_out
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} mtmr_pre_s;

	mtmr_pre_s state_reg;
	mtmr_pre_s state_next;
	logic [WIDTH:0] mask;
	logic [3:0] code;

	always_comb
	begin
		code = (prescale_select > MTMR_PRESCALE_MAX) ?
			MTMR_PRESCALE_MAX : prescale_select;
		mask = ({{WIDTH{1'b0}}, 1'b1} << code) - 1'b1;
		state_next = state_reg;
		if (clear)
			state_next.count = '0;
		else if (tick_in)
			state_next.count = state_reg.count + 1'b1;
	end

	assign tick_out = tick_in & ~clear &
		((state_reg.count & mask[WIDTH-1:0]) == mask[WIDTH-1:0]);

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

endmodule
`default_nettype wire

/* File: tb/mtmr_props.sv */
`timescale 1ns/1ns
`default_nettype none
module mtmr_props
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic ext_count_pin,
	input wire logic fixed_freq_clock,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic deep_stop_wake,
	input wire logic light_stop_reset,
	input wire logic debug_active,
	input wire logic overflow_irq
);
	wire logic rd = psel && penable && pready && !pwrite;
	wire logic setup = psel && !penable;
	wire logic sc_wr = setup && pwrite && paddr == 8'h00 && pstrb[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_rdy; setup |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_one; !setup |=> !pready; endproperty
	a_one: assert property (p_one) else $error("stray ready");
	property p_err; setup && paddr > 8'h10 |=> pslverr; endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_ok; setup && paddr[1:0] == 2'h0 && paddr <= 8'h10 |=> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("false slave error");
	property p_sc;
		rd && paddr == 8'h00 |-> prdata[31:8] == 24'h0 && !prdata[5] &&
			prdata[3:0] == 4'h0;
	endproperty
	a_sc: assert property (p_sc) else $error("status zeros wrong");
	property p_cc; rd && paddr == 8'h04 |-> prdata[31:6] == 26'h0; endproperty
	a_cc: assert property (p_cc) else $error("config zeros wrong");
	property p_irq; sc_wr && !pwdata[6] |-> ##2 !overflow_irq; endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");
	property p_stop; (stop_mode && !psel) [*3] |-> $stable(overflow_irq);
	endproperty
	a_stop: assert property (p_stop) else $error("irq moved in stop");
	property p_dbg; (debug_active && !psel) [*3] |-> $stable(overflow_irq);
	endproperty
	a_dbg: assert property (p_dbg) else $error("irq moved in debug");
	c_flag: cover property (rd && paddr == 8'h00 && prdata[7]);
	c_irq: cover property (overflow_irq);
	c_err: cover property (pslverr);
endmodule
bind mtmr_top mtmr_props u_mtmr_props (.*);
`default_nettype wire

/* File: tb/mtmr_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module mtmr_bench
	import mtmr_pkg::*;
;
	localparam logic [7:0] SC = MTMR_STATUS_CONTROL_ADDR;
	localparam logic [7:0] CC = MTMR_CLOCK_CONFIG_ADDR;
	localparam logic [7:0] CV = MTMR_COUNT_VALUE_ADDR;
	localparam logic [7:0] WL = MTMR_WRAP_LIMIT_ADDR;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic ext_count_pin = 1'b0;
	logic fixed_freq_clock = 1'b0;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic deep_stop_wake = 1'b0;
	logic light_stop_reset = 1'b0;
	logic debug_active = 1'b0;
	wire logic pready;
	wire logic pslverr;
	wire logic overflow_irq;
	wire logic [31:0] prdata;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed = 71;
	int cnt, lim, flag, k, a, b;
	mtmr_top u_mtmr_top (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.ext_count_pin(ext_count_pin), .fixed_freq_clock(fixed_freq_clock),
		.wait_mode(wait_mode), .stop_mode(stop_mode),
		.deep_stop_wake(deep_stop_wake), .light_stop_reset(light_stop_reset),
		.debug_active(debug_active), .overflow_irq(overflow_irq));
	always #2 core_clk = ~core_clk;
	task automatic complete_run;
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fail_count++;
			complete_run;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready, read data and error are taken at the rising edge that ends it.
	task automatic apb(input logic w, input logic [7:0] ad, input int d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= 32'(d);
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Clears and starts the counter, runs it n+2 ticks, then halts it.
	task automatic count_run(input int n);
		apb(1'b1, SC, 32'h20);
		repeat (n) @(posedge core_clk);
		apb(1'b1, SC, 32'h10);
	endtask
	task automatic step(input int inc);
		int t;
		t = (lim == 0) ? 255 : lim;
		repeat (inc)
		begin
			flag |= (cnt == t);
			cnt = (cnt == t) ? 0 : cnt + 1;
		end
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(i * 4), 0);
			chk(rd, (i == 0) ? 32'h10 : 32'h0);
		end
		apb(1'b1, CV, 32'h55);
		apb(1'b0, CV, 0);
		chk(rd, 32'h0);
		apb(1'b1, SC, 32'hFF);
		apb(1'b0, SC, 0);
		chk(rd, 32'h50);
		apb(1'b1, CC, 32'hFF);
		apb(1'b0, CC, 0);
		chk(rd, 32'h3F);
		apb(1'b0, 8'h14, 0);
		chk({rd[30:0], err}, 32'h1);
		$display("test registers done");
		for (int p = 0; p < 10; p++)
		begin
			lim = (p % 3 == 0) ? 0 : ($random(seed) & 255);
			k = 300 + ($random(seed) & 1023);
			apb(1'b1, CC, p);
			apb(1'b1, SC, 32'h10);
			apb(1'b1, WL, lim);
			count_run(k);
			cnt = 0;
			flag = 0;
			step((k + 2) >> ((p > 8) ? 8 : p));
			apb(1'b0, CV, 0);
			chk(rd, 32'(cnt));
			apb(1'b0, SC, 0);
			chk(rd, 32'(flag * 128 + 16));
		end
		$display("test prescale done");
		apb(1'b1, CC, 0);
		apb(1'b1, WL, 3);
		count_run(20);
		chk({31'h0, overflow_irq}, 32'h0);
		apb(1'b1, SC, 32'h10);
		apb(1'b0, SC, 0);
		chk(rd, 32'h90);
		apb(1'b1, SC, 32'hD0);
		repeat (2) @(negedge core_clk);
		chk({31'h0, overflow_irq}, 32'h1);
		apb(1'b0, SC, 0);
		apb(1'b1, SC, 32'h10);
		apb(1'b0, SC, 0);
		chk(rd, 32'h10);
		apb(1'b1, SC, 32'h20);
		repeat (10) @(posedge core_clk);
		apb(1'b0, SC, 0);
		repeat (4) @(posedge core_clk);
		apb(1'b1, SC, 32'h00);
		apb(1'b1, SC, 32'h10);
		apb(1'b0, SC, 0);
		chk(rd, 32'h90);
		apb(1'b1, SC, 32'h30);
		apb(1'b0, SC, 0);
		chk(rd, 32'h10);
		count_run(20);
		apb(1'b1, WL, 3);
		apb(1'b0, SC, 0);
		chk(rd, 32'h10);
		$display("test flag done");
		apb(1'b1, WL, 0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, SC, 32'h20);
			wait_mode <= (i == 0);
			stop_mode <= (i == 1);
			debug_active <= (i == 2);
			deep_stop_wake <= (i == 3);
			light_stop_reset <= (i == 4);
			repeat (3) @(posedge core_clk);
			deep_stop_wake <= 1'b0;
			light_stop_reset <= 1'b0;
			apb(1'b0, CV, 0);
			a = rd;
			repeat (7) @(posedge core_clk);
			apb(1'b0, CV, 0);
			chk({31'h0, rd == a}, (i == 0) ? 32'h0 : 32'h1);
			stop_mode <= 1'b0;
			debug_active <= 1'b0;
			apb(1'b0, SC, 0);
			chk({31'h0, rd[4]}, (i > 2) ? 32'h1 : 32'h0);
		end
		$display("test modes done");
		for (int s = 0; s < 4; s++)
		begin
			a = 1 + ($random(seed) & 7);
			b = 1 + ($random(seed) & 7);
			apb(1'b1, CC, s * 16);
			apb(1'b1, SC, 32'h20);
			@(posedge core_clk);
			for (int j = 0; j < 20; j++)
			begin
				// Pulses last four bus cycles, well inside the pin rate limit.
				fixed_freq_clock <= (j < 2 * a) && (j % 2 == 0);
				ext_count_pin <= (j < 2 * b) && (j % 2 == 0);
				repeat (4) @(posedge core_clk);
			end
			repeat (8) @(posedge core_clk);
			apb(1'b1, SC, 32'h10);
			apb(1'b0, CV, 0);
			chk(rd, (s == 0) ? 91 : ((s == 1) ? a : b));
		end
		$display("test sources done");
		complete_run;
	end
endmodule
`default_nettype wire
